// file: logic/txm_top.sv
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Function
// - Twenty-two independent channel pin multiplexers
// - Negative/indication pin drives in single NRZ, RZ
// - Bits seven to five choose indication source
// - Indication changes on active clock edge in NRZ, every cycle in RZ
// - Indication output always active high
// - Clock pin is clock in NRZ modes
// - Data inputs sampled on active clock edge in NRZ modes, every cycle in RZ
// - Bit four picks rising or falling edge
// - Clock pin carries negative data in RZ
// - Master clock loss then return resets device
// - Dual rail: differing inputs pulse, equal spaces
// - Bit three inverts transmit data level
module txm_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [txm_pkg::ADR_W-1:0] adr_i,
    input wire logic [txm_pkg::SEL_W-1:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Channel pins
    input wire logic [txm_pkg::NCH-1:0] tx_single_data_i,
    input wire logic [txm_pkg::NCH-1:0] tx_neg_data_i,
    output logic [txm_pkg::NCH-1:0] tx_indication_out_o,
    output logic [txm_pkg::NCH-1:0] tx_indication_oe_o,
    input wire logic [txm_pkg::NCH-1:0] tx_system_clock_i,
    // Indication conditions per channel
    input wire logic [txm_pkg::NCH-1:0] arbitrary_pattern_i,
    input wire logic [txm_pkg::NCH-1:0] tx_all_ones_i,
    input wire logic [txm_pkg::NCH-1:0] output_short_i,
    input wire logic [txm_pkg::NCH-1:0] tx_loss_of_signal_i,
    input wire logic [txm_pkg::NCH-1:0] excess_zeros_i,
    input wire logic [txm_pkg::NCH-1:0] bipolar_violation_i,
    input wire logic [txm_pkg::NCH-1:0] system_loss_of_signal_i,
    // Line side data
    output logic [txm_pkg::NCH-1:0] line_data_o,
    output logic [txm_pkg::NCH-1:0] line_pos_o,
    output logic [txm_pkg::NCH-1:0] line_neg_o,
    output logic [txm_pkg::NCH-1:0] line_strobe_o,
    // Master clock and straps
    input wire logic master_clock_i,
    input wire logic [txm_pkg::SEL_STRAP_W-1:0] master_clock_freq_select_i,
    output logic [txm_pkg::SEL_STRAP_W-1:0] master_clock_freq_o,
    output logic dev_reset_o,
    // Interrupt
    output logic irq_o
);
    import txm_pkg::*;

    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYC - 1);
    localparam logic [CNT_W-1:0] DUTY_MIN = CNT_W'(DUTY_MIN_CYC);
    localparam logic [CNT_W-1:0] WIN_LEN = CNT_W'(WIN_CYC);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [NCH-1:0][CFG_W-1:0] cfg;
        logic mclk_s1;
        logic mclk_s2;
        logic [CNT_W-1:0] win;
        logic [CNT_W-1:0] hi;
        txm_mon_t mon;
        logic autorst;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic [SEL_STRAP_W-1:0] strap_s1;
        logic [SEL_STRAP_W-1:0] strap_s2;
        logic [SEL_STRAP_W-1:0] strap;
        logic [1:0] strap_age;
    } txm_top_t;

    txm_top_t s_r;
    txm_top_t s_nxt;
    logic [CNT_W-1:0] hi_now;
    logic duty_ok;
    logic req;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic chan_rst;

    // --------------------------------------------------
    // Next state
    // --------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        irq_set = '0;
        irq_clr = '0;
        req = cyc_i && stb_i && !s_r.ack;
        s_nxt.ack = req;
        s_nxt.autorst = 1'b0;

        // Master clock duty monitor
        s_nxt.mclk_s1 = master_clock_i;
        s_nxt.mclk_s2 = s_r.mclk_s1;
        hi_now = s_r.hi + CNT_W'(s_r.mclk_s2);
        duty_ok = (hi_now >= DUTY_MIN) && ((WIN_LEN - hi_now) >= DUTY_MIN);
        if (s_r.win == WIN_LAST) begin
            s_nxt.win = '0;
            s_nxt.hi = '0;
            case (s_r.mon)
                MON_OK: begin
                    if (!duty_ok) begin
                        s_nxt.mon = MON_LOST;
                        irq_set[IRQ_LOST] = 1'b1;
                    end
                end
                MON_LOST: begin
                    if (duty_ok) begin
                        s_nxt.mon = MON_OK;
                        s_nxt.autorst = 1'b1;
                        irq_set[IRQ_AUTORST] = 1'b1;
                    end
                end
                default: s_nxt.mon = MON_OK;
            endcase
        end else begin
            s_nxt.win = s_r.win + CNT_W'(1);
            s_nxt.hi = hi_now;
        end

        // Strap capture after reset
        s_nxt.strap_s1 = master_clock_freq_select_i;
        s_nxt.strap_s2 = s_r.strap_s1;
        if (s_r.strap_age != '1) begin
            s_nxt.strap_age = s_r.strap_age + 2'h1;
        end
        // Capture once the second stage holds a pin sample
        if (s_r.strap_age == STRAP_AGE) begin
            s_nxt.strap = s_r.strap_s2;
        end

        // Read data
        if (req) begin
            s_nxt.rdata = '0;
            if (adr_i == OFS_STATUS) begin
                s_nxt.rdata[SEL_STRAP_W-1:0] = s_r.strap;
                s_nxt.rdata[STAT_LOST_BIT] = (s_r.mon == MON_LOST);
            end else if (adr_i == OFS_IRQ_STAT) begin
                s_nxt.rdata[IRQ_W-1:0] = s_r.irq;
            end else if (adr_i == OFS_IRQ_MASK) begin
                s_nxt.rdata[IRQ_W-1:0] = s_r.mask;
            end else begin
                for (int i = 0; i < NCH; i++) begin
                    if (adr_i == OFS_CFG_BASE + ADR_W'(4 * i)) begin
                        s_nxt.rdata[CFG_W-1:0] = s_r.cfg[i];
                    end
                end
            end
        end

        // Writes take effect on the acknowledging edge
        if (s_r.ack && cyc_i && stb_i && we_i && sel_i[0]) begin
            if (adr_i == OFS_IRQ_STAT) begin
                irq_clr = dat_i[IRQ_W-1:0];
            end else if (adr_i == OFS_IRQ_MASK) begin
                s_nxt.mask = dat_i[IRQ_W-1:0];
            end else begin
                for (int i = 0; i < NCH; i++) begin
                    if (adr_i == OFS_CFG_BASE + ADR_W'(4 * i)) begin
                        s_nxt.cfg[i] = dat_i[CFG_W-1:0];
                    end
                end
            end
        end

        // Sticky events, set wins over clear
        s_nxt.irq = (s_r.irq & ~irq_clr) | irq_set;

        // Automatic device reset returns configuration to defaults
        if (s_r.autorst) begin
            for (int i = 0; i < NCH; i++) begin
                s_nxt.cfg[i] = CFG_RST;
            end
            s_nxt.mask = MASK_RST;
        end
    end

    // --------------------------------------------------
    // State register
    // --------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '{mon: MON_OK, cfg: {NCH{CFG_RST}}, mask: MASK_RST, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign chan_rst = rst_i || s_r.autorst;
    assign ack_o = s_r.ack;
    assign dat_o = s_r.rdata;
    assign irq_o = |(s_r.irq & s_r.mask);
    assign dev_reset_o = s_r.autorst;
    assign master_clock_freq_o = s_r.strap;

    // --------------------------------------------------
    // Channels
    // --------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_chan
        txm_chan u_chan (
            .clk_i(clk_i),
            .rst_i(chan_rst),
            .cfg_i(s_r.cfg[g]),
            .cond_i({system_loss_of_signal_i[g], bipolar_violation_i[g], excess_zeros_i[g],
                     tx_loss_of_signal_i[g], output_short_i[g], tx_all_ones_i[g],
                     arbitrary_pattern_i[g]}),
            .data_pin_i(tx_single_data_i[g]),
            .neg_ind_pin_i(tx_neg_data_i[g]),
            .clk_neg_pin_i(tx_system_clock_i[g]),
            .ind_o(tx_indication_out_o[g]),
            .ind_oe_o(tx_indication_oe_o[g]),
            .data_o(line_data_o[g]),
            .pos_o(line_pos_o[g]),
            .neg_o(line_neg_o[g]),
            .strobe_o(line_strobe_o[g])
        );
    end

endmodule // txm_top

// file: logic/txm_pkg.sv
package txm_pkg;

    // --------------------------------------------------
    // Channel count and configuration layout
    // --------------------------------------------------
    localparam int NCH = 22;
    localparam int CFG_W = 8;
    localparam int IND_SEL_LSB = 5;
    localparam int IND_SEL_W = 3;
    localparam int EDGE_BIT = 4;
    localparam int INV_BIT = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int COND_W = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

    // --------------------------------------------------
    // Interface modes
    // --------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_SR_NRZ = 2'h0;
    localparam logic [MODE_W-1:0] MODE_DR_NRZ = 2'h1;
    localparam logic [MODE_W-1:0] MODE_DR_RZ = 2'h2;

    // --------------------------------------------------
    // Indication choices and condition input positions
    // --------------------------------------------------
    localparam logic [IND_SEL_W-1:0] IND_PATTERN = 3'h0;
    localparam logic [IND_SEL_W-1:0] IND_ALL_ONES = 3'h1;
    localparam logic [IND_SEL_W-1:0] IND_SHORT = 3'h2;
    localparam logic [IND_SEL_W-1:0] IND_TX_LOS = 3'h3;
    localparam logic [IND_SEL_W-1:0] IND_EXZ = 3'h4;
    localparam logic [IND_SEL_W-1:0] IND_BPV = 3'h5;
    localparam logic [IND_SEL_W-1:0] IND_EXZ_BPV = 3'h6;
    localparam logic [IND_SEL_W-1:0] IND_SYS_LOS = 3'h7;
    localparam int C_PATTERN = 0;
    localparam int C_ALL_ONES = 1;
    localparam int C_SHORT = 2;
    localparam int C_TX_LOS = 3;
    localparam int C_EXZ = 4;
    localparam int C_BPV = 5;
    localparam int C_SYS_LOS = 6;

    // --------------------------------------------------
    // Register map
    // --------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CFG_BASE = 8'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h60;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h64;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h68;
    localparam int STAT_LOST_BIT = 4;
    localparam int IRQ_W = 2;
    localparam int IRQ_LOST = 0;
    localparam int IRQ_AUTORST = 1;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;
    localparam int SEL_W = 4;

    // --------------------------------------------------
    // Master clock monitor timing
    // --------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int MCLK_LOSS_US = 10;
    localparam int DUTY_MIN_PCT = 30;
    localparam int WIN_CYC = MCLK_LOSS_US * 1000 / CLK_PERIOD_NS;
    localparam int DUTY_MIN_CYC = (WIN_CYC * DUTY_MIN_PCT + 99) / 100;
    localparam int CNT_W = 12;
    localparam int SEL_STRAP_W = 4;
    localparam logic [1:0] STRAP_AGE = 2'h2;

    typedef enum logic [1:0] {
        MON_OK = 2'b01,
        MON_LOST = 2'b10
    } txm_mon_t;

endpackage

// file: logic/txm_chan.sv
`timescale 1ns/10ps
module txm_chan (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire logic [txm_pkg::CFG_W-1:0] cfg_i,
    input wire logic [txm_pkg::COND_W-1:0] cond_i,
    // Pins
    input wire logic data_pin_i,
    input wire logic neg_ind_pin_i,
    input wire logic clk_neg_pin_i,
    output logic ind_o,
    output logic ind_oe_o,
    // Line side
    output logic data_o,
    output logic pos_o,
    output logic neg_o,
    output logic strobe_o
);
    import txm_pkg::*;

    typedef struct packed {
        logic [2:0] tclk;
        logic [1:0] dat;
        logic [1:0] neg;
        logic [1:0] cneg;
        logic ind;
        logic data;
        logic pos;
        logic negp;
        logic strobe;
    } txm_ch_t;

    txm_ch_t s_r;
    txm_ch_t s_nxt;
    logic [MODE_W-1:0] mode;
    logic inv;
    logic edge_act;
    logic p_in;
    logic n_in;
    logic cond_sel;

    // --------------------------------------------------
    // Next state
    // --------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        mode = cfg_i[MODE_LSB +: MODE_W];
        inv = cfg_i[INV_BIT];
        s_nxt.tclk = {s_r.tclk[1:0], clk_neg_pin_i};
        s_nxt.dat = {s_r.dat[0], data_pin_i};
        s_nxt.neg = {s_r.neg[0], neg_ind_pin_i};
        s_nxt.cneg = {s_r.cneg[0], clk_neg_pin_i};
        if (cfg_i[EDGE_BIT]) begin
            edge_act = !s_r.tclk[1] && s_r.tclk[2];
        end else begin
            edge_act = s_r.tclk[1] && !s_r.tclk[2];
        end
        case (cfg_i[IND_SEL_LSB +: IND_SEL_W])
            IND_PATTERN: cond_sel = cond_i[C_PATTERN];
            IND_ALL_ONES: cond_sel = cond_i[C_ALL_ONES];
            IND_SHORT: cond_sel = cond_i[C_SHORT];
            IND_TX_LOS: cond_sel = cond_i[C_TX_LOS];
            IND_EXZ: cond_sel = cond_i[C_EXZ];
            IND_BPV: cond_sel = cond_i[C_BPV];
            IND_EXZ_BPV: cond_sel = cond_i[C_EXZ] | cond_i[C_BPV];
            default: cond_sel = cond_i[C_SYS_LOS];
        endcase
        p_in = s_r.dat[1] ^ inv;
        n_in = (mode == MODE_DR_RZ) ? (s_r.cneg[1] ^ inv) : (s_r.neg[1] ^ inv);
        s_nxt.strobe = 1'b0;
        case (mode)
            MODE_SR_NRZ: begin
                if (edge_act) begin
                    s_nxt.data = p_in;
                    s_nxt.ind = cond_sel;
                    s_nxt.strobe = 1'b1;
                end
            end
            MODE_DR_NRZ: begin
                if (edge_act) begin
                    s_nxt.pos = p_in && !n_in;
                    s_nxt.negp = n_in && !p_in;
                    s_nxt.strobe = 1'b1;
                end
            end
            MODE_DR_RZ: begin
                s_nxt.pos = p_in && !n_in;
                s_nxt.negp = n_in && !p_in;
                s_nxt.ind = cond_sel;
                s_nxt.strobe = 1'b1;
            end
            default: begin
                s_nxt.pos = 1'b0;
                s_nxt.negp = 1'b0;
            end
        endcase
    end

    // --------------------------------------------------
    // State register
    // --------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ind_o = s_r.ind;
    assign ind_oe_o = (cfg_i[MODE_LSB +: MODE_W] == MODE_SR_NRZ) ||
                      (cfg_i[MODE_LSB +: MODE_W] == MODE_DR_RZ);
    assign data_o = s_r.data;
    assign pos_o = s_r.pos;
    assign neg_o = s_r.negp;
    assign strobe_o = s_r.strobe;

endmodule // txm_chan

// file: testbench/txm_chk.sv
`timescale 1ns/10ps
module txm_chk (
    // Bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [txm_pkg::ADR_W-1:0] adr_i,
    input wire logic [txm_pkg::SEL_W-1:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Channels and master clock
    input wire logic [txm_pkg::NCH-1:0] tx_indication_out_o,
    input wire logic [txm_pkg::NCH-1:0] tx_indication_oe_o,
    input wire logic [txm_pkg::NCH-1:0] line_data_o,
    input wire logic [txm_pkg::NCH-1:0] line_pos_o,
    input wire logic [txm_pkg::NCH-1:0] line_neg_o,
    input wire logic [txm_pkg::NCH-1:0] line_strobe_o,
    input wire logic [txm_pkg::SEL_STRAP_W-1:0] master_clock_freq_select_i,
    input wire logic [txm_pkg::SEL_STRAP_W-1:0] master_clock_freq_o,
    input wire logic dev_reset_o
);
    import txm_pkg::*;
    logic [CFG_W-1:0] cfg0_r;
    logic dr_r;
    logic [3:0] age_r;
    // ----------------------------------------
    // Shadow of channel 0 configuration
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        dr_r <= dev_reset_o;
        age_r <= rst_i ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
        if (rst_i || dev_reset_o) begin
            cfg0_r <= CFG_RST;
        end else if (ack_o && we_i && sel_i[0] && adr_i == OFS_CFG_BASE) begin
            cfg0_r <= dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || dev_reset_o || dr_r);
    sequence s_rz_held;
        (cfg0_r[1:0] == MODE_DR_RZ) [*4];
    endsequence
    sequence s_nrz_strobe;
        (cfg0_r[1:0] == MODE_SR_NRZ) [*4] ##0 line_strobe_o[0];
    endsequence
    a_ind_on_edge: assert property (((tx_indication_out_o ^ $past(tx_indication_out_o)) & ~line_strobe_o) == '0)
        else $error("indication changed without a sample");
    a_line_on_edge: assert property (((line_data_o ^ $past(line_data_o)) & ~line_strobe_o) == '0)
        else $error("line data changed without a sample");
    a_pos_neg_excl: assert property ((line_pos_o & line_neg_o) == '0)
        else $error("positive and negative pulse together");
    a_oe_by_mode: assert property (tx_indication_oe_o[0] != cfg0_r[0])
        else $error("indication enable wrong for mode");
    a_rz_strobe: assert property (s_rz_held |-> line_strobe_o[0])
        else $error("no sample every cycle in rz mode");
    a_nrz_pulse: assert property (s_nrz_strobe |=> !line_strobe_o[0])
        else $error("sample strobe longer than one cycle");
    a_dev_rst_pulse: assert property (disable iff (rst_i) dev_reset_o |=> !dev_reset_o [*8])
        else $error("automatic reset repeated");
    a_strap_cap: assert property (age_r == 4'h8 |-> master_clock_freq_o == master_clock_freq_select_i)
        else $error("strap code not captured");
    a_strap_hold: assert property (age_r > 4'h8 |-> $stable(master_clock_freq_o))
        else $error("strap code changed");
endmodule // txm_chk

bind txm_top txm_chk chk_u (.*);

// file: testbench/txm_sys_model.sv
`timescale 1ns/10ps
module txm_sys_model (
    // Pins toward the block
    output logic [txm_pkg::NCH-1:0] clk_o,
    output logic [txm_pkg::NCH-1:0] pos_o,
    output logic [txm_pkg::NCH-1:0] neg_o
);
    import txm_pkg::*;
    initial begin
        clk_o = '0;
        pos_o = '0;
        neg_o = '0;
    end
    // Eight bits, data moves on the inactive edge; 32 ns stands in for the line rate
    task automatic frame(input int ch, input logic fall, input logic [7:0] p, input logic [7:0] q);
        // Move pins off the sampling edge
        #1;
        for (int i = 0; i < 8; i++) begin
            clk_o[ch] = fall;
            pos_o[ch] = p[i];
            neg_o[ch] = q[i];
            #16;
            clk_o[ch] = !fall;
            #16;
        end
        clk_o[ch] = fall;
        pos_o[ch] = !p[7];
        neg_o[ch] = !q[7];
    endtask
    // No clock in rz mode: the clock pin carries negative data
    task automatic rz(input int ch, input logic p, input logic n);
        #1;
        pos_o[ch] = p;
        clk_o[ch] = n;
    endtask
endmodule // txm_sys_model

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import txm_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, mck = 1'b0, mck_on = 1'b1;
    logic [7:0] adr_i = '0, le;
    logic [3:0] sel_i = '0, strap = '0, mfreq;
    logic [31:0] dat_i = '0, dat_o;
    logic ack_o, devrst, irq, mon_on = 1'b0;
    logic [NCH-1:0] cnd [7] = '{default: '0};
    logic [NCH-1:0] ind, oe, mdl_clk, mdl_pos, mdl_neg, ln_d, ln_p, ln_n, ln_s, neg_w;
    logic [31:0] rd_q [$];
    logic [7:0] ln_q [$];
    int errors = 0, samples_checked = 0, ticks = 0, mon_ch = 0;
    always #2 clk_i = ~clk_i;
    always #20 if (mck_on) mck = ~mck;
    assign neg_w = (oe & ind) | (~oe & mdl_neg);
    txm_sys_model sys_u (.clk_o(mdl_clk), .pos_o(mdl_pos), .neg_o(mdl_neg));
    txm_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_single_data_i(mdl_pos),
        .tx_neg_data_i(neg_w), .tx_indication_out_o(ind), .tx_indication_oe_o(oe), .tx_system_clock_i(mdl_clk),
        .arbitrary_pattern_i(cnd[0]), .tx_all_ones_i(cnd[1]), .output_short_i(cnd[2]),
        .tx_loss_of_signal_i(cnd[3]), .excess_zeros_i(cnd[4]), .bipolar_violation_i(cnd[5]),
        .system_loss_of_signal_i(cnd[6]), .line_data_o(ln_d), .line_pos_o(ln_p), .line_neg_o(ln_n),
        .line_strobe_o(ln_s), .master_clock_i(mck), .master_clock_freq_select_i(strap),
        .master_clock_freq_o(mfreq), .dev_reset_o(devrst), .irq_o(irq)
    );
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) chk("ack", 1, 0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    function automatic logic ind_exp(input logic [2:0] s, input int ch);
        case (s)
            IND_EXZ_BPV: return cnd[C_EXZ][ch] | cnd[C_BPV][ch];
            IND_SYS_LOS: return cnd[C_SYS_LOS][ch];
            default: return cnd[s][ch];
        endcase
    endfunction
    // ----------------------------------------
    // Output watcher and timeout
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we_i && rd_q.size() > 0) chk("dat_o", rd_q.pop_front(), dat_o);
        if (mon_on && ln_s[mon_ch] === 1'b1) begin
            le = (ln_q.size() > 0) ? ln_q.pop_front() : 8'hff;
            chk("line", {28'h0, le[3:0]}, {28'h0, {ind[mon_ch], ln_d[mon_ch], ln_p[mon_ch], ln_n[mon_ch]} & le[7:4]});
        end
    end
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] cfg, p, q;
        int ch, n;
        void'($urandom(15115));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            strap <= 4'(c);
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (10) @(posedge clk_i);
            chk("strap", 32'(c), {28'h0, mfreq});
        end
        rd(OFS_CFG_BASE + 8'h54, {24'h0, CFG_RST});
        rd(OFS_IRQ_MASK, {30'h0, MASK_RST});
        rd(OFS_STATUS, 32'h0f);
        wb(1'b1, 8'h80, 32'hff);
        rd(8'h80, 32'h0);
        for (int k = 0; k < 8; k++) begin
            ch = (k == 0) ? 0 : $urandom_range(NCH - 1);
            cfg = {3'(k), 1'(k >> 2), 1'(k >> 1), 2'b00, 1'(k)};
            wb(1'b1, 8'(ch * 4), {24'h0, cfg});
            rd(8'(ch * 4), {24'h0, cfg});
            @(posedge clk_i);
            foreach (cnd[i]) cnd[i] <= NCH'($urandom);
            p = 8'($urandom);
            q = 8'($urandom);
            @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                if (cfg[0]) ln_q.push_back({6'h0c, (p[i] ^ cfg[3]) & ~(q[i] ^ cfg[3]),
                                            (q[i] ^ cfg[3]) & ~(p[i] ^ cfg[3])});
                else ln_q.push_back({4'hc, ind_exp(3'(k), ch), p[i] ^ cfg[3], 2'b00});
            end
            mon_ch <= ch;
            mon_on <= 1'b1;
            sys_u.frame(ch, cfg[4], p, q);
            repeat (12) @(posedge clk_i);
            mon_on <= 1'b0;
            chk("line count", 0, 32'(ln_q.size()));
            chk("oe", {31'h0, !cfg[0]}, {31'h0, oe[ch]});
        end
        for (int j = 0; j < 8; j++) begin
            wb(1'b1, 8'h00, {24'h0, 3'(j), 5'h0a});
            @(posedge clk_i);
            foreach (cnd[i]) cnd[i] <= NCH'($urandom);
            sys_u.rz(0, j[1], j[0]);
            repeat (8) @(posedge clk_i);
            chk("rz", {29'h3, ind_exp(3'(j), 0), ~j[1] & j[0], ~j[0] & j[1]},
                {27'h0, ln_s[0], oe[0], ind[0], ln_p[0], ln_n[0]});
        end
        wb(1'b1, OFS_IRQ_MASK, 32'h1);
        mck_on <= 1'b0;
        for (n = 0; n < 8000 && irq !== 1'b1; n++) @(posedge clk_i);
        chk("irq lost", 1, {31'h0, irq});
        chk("early reset", 0, {31'h0, devrst});
        rd(OFS_STATUS, 32'h1f);
        mck_on <= 1'b1;
        for (n = 0; n < 8000 && devrst !== 1'b1; n++) @(posedge clk_i);
        chk("dev reset", 1, {31'h0, devrst});
        repeat (3) @(posedge clk_i);
        chk("irq masked", 0, {31'h0, irq});
        rd(OFS_IRQ_STAT, 32'h3);
        rd(OFS_CFG_BASE, 32'h0);
        wb(1'b1, OFS_IRQ_MASK, 32'h3);
        @(posedge clk_i);
        chk("irq set", 1, {31'h0, irq});
        wb(1'b1, OFS_IRQ_STAT, 32'h3);
        rd(OFS_IRQ_STAT, 32'h0);
        chk("irq clear", 0, {31'h0, irq});
        repeat (4) @(posedge clk_i);
        chk("reads left", 0, 32'(rd_q.size()));
        report_and_stop();
    end
endmodule // testbench
